// *** bench/pcr_host_model.sv ***
`timescale 1ns/1ns
// Register host; one strobe per request, changed just after the edge
module pcr_host_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Write; released lines carry inverted values so stale data never matches
  task automatic write(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // Read; answer valid for the one cycle after the taking edge
  task automatic read(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    ok       = (reg_rvalid === 1'b1);
    d        = reg_rdata;
  endtask
endmodule

// *** bench/pmic_config_status_regs_test.sv ***
`timescale 1ns/1ns
module pmic_config_status_regs_test;
  import pcr_pkg::*;
  // Short release delays keep the run brief
  localparam int unsigned DLY [8] = '{4, 6, 8, 10, 12, 14, 16, 20};
  localparam logic [7:0]  ID      = 8'hA7;  // Arbitrary value
  logic       ref_clk = 1'b0;
  logic       arst_n, reg_wr, reg_rd, reg_rvalid, disable_entry, locked_entry;
  logic       mcu_rst_pin_n, sync_in_done, reset_hold, ena_config, mcu_reset_n;
  logic       ph_post, ph_pre, ph_sync, spread, sin_en, sout_en, wd_pulse, dc_pulse;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, wd_cmd, dc, dc_inv, w, m, ex, su_w;
  logic [7:0] evt [4];
  logic [7:0] stat [7];
  logic [3:0] su_in, su_out;
  logic [2:0] rel_dly;
  int         err_total, checks_done, cyc, n;

  // Clock
  always #25 ref_clk = ~ref_clk;

  pcr_host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  pcr_regs #(.REL_DLY_CYC(DLY), .CHIP_ID(ID)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .disable_entry(disable_entry), .locked_entry(locked_entry), .mcu_rst_pin_n(mcu_rst_pin_n),
    .monitor_uv_evt(evt[0]), .overtemp_fault_evt(evt[1]), .overtemp_warn_evt(evt[2]),
    .overcurrent_warn_evt(evt[3]), .overtemp_status_in(stat[0]), .vmon_status_in(stat[1]),
    .device_state_in(stat[2]), .protection_status_in(stat[3]), .wwd_status_in(stat[4]),
    .prog_support_in(stat[5]), .post_buck_status_in(stat[6]), .startup_enables_in(su_in),
    .sync_in_done(sync_in_done), .reset_hold(reset_hold), .reset_release_delay(rel_dly),
    .ena_config(ena_config), .startup_enables(su_out), .post_stepdown_phase(ph_post),
    .pre_regulator_phase(ph_pre), .sync_phase(ph_sync), .spread_spectrum_enable(spread),
    .sync_input_enable(sin_en), .sync_output_enable(sout_en), .wd_service_cmd(wd_cmd),
    .wd_service_pulse(wd_pulse), .dev_ctrl(dc), .dev_ctrl_inv(dc_inv),
    .dev_ctrl_pulse(dc_pulse), .mcu_reset_n(mcu_reset_n));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.read(a, d, ok);
    check("rvalid", {7'h00, ok}, 8'h01);
    check($sformatf("reg %h", a), d, exp);
  endtask

  // One-cycle pulse on a same-clock input
  task automatic tick(ref logic s);
    @(posedge ref_clk);
    #1;
    s = 1'b1;
    @(posedge ref_clk);
    #1;
    s = 1'b0;
  endtask

  // Expected clock register value after a write of v over old value o
  function automatic logic [7:0] ck_exp(input logic [7:0] v, input logic [7:0] o);
    return (v & 8'h77) | (o & 8'h02);
  endfunction

  initial
  begin
    logic [5:0] ra [12];
    logic [7:0] rv [12];
    ra = '{6'h00, 6'h01, 6'h22, 6'h23, 6'h24, 6'h25, 6'h33, 6'h34, 6'h35, 6'h3B, 6'h3C, 6'h3F};
    rv = '{8'hF3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hD3, ID, 8'h00};
    {arst_n, disable_entry, locked_entry, sync_in_done} = 4'h0;
    {mcu_rst_pin_n, reset_hold, su_in} = 6'h3F;
    evt = '{default: 8'h00};
    stat = PCR_STAT_RST;
    void'($urandom(32'hf3c284ec));
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 12; i++) rd_chk(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) rd_chk(PCR_STAT_ADDR[i], PCR_STAT_RST[i]);
    $display("test reset values done");
    // Status copies of random inputs
    for (int i = 0; i < 7; i++) stat[i] = 8'($urandom);
    for (int i = 0; i < 7; i++) rd_chk(PCR_STAT_ADDR[i], stat[i]);
    $display("test status done");
    // Start-up register: upper nibble is read-only, writes land only in 3:0
    for (int k = 0; k < 6; k++)
    begin
      w = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      su_in = 4'($urandom);
      i_host.write(PCR_A_STARTUP_CFG, w);
      su_w = w;
      rd_chk(PCR_A_STARTUP_CFG, {su_in, w[3:0]});
      check("startup out", {su_out, ena_config, rel_dly}, {su_in, w[3:0]});
    end
    $display("test startup done");
    // Clock register, request bit only sets by a written one
    ex = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      w = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      i_host.write(PCR_A_CLOCK_CFG, w);
      ex = ck_exp(w, ex);
      rd_chk(PCR_A_CLOCK_CFG, ex);
      check("clk out", {1'b0, ph_post, ph_pre, ph_sync, 1'b0, spread, sin_en, sout_en}, ex);
    end
    i_host.write(PCR_A_CLOCK_CFG, 8'h02);
    tick(sync_in_done);
    rd_chk(PCR_A_CLOCK_CFG, 8'h00);
    $display("test clock done");
    // Flags: set by events, cleared by written ones only
    for (int i = 0; i < 4; i++) evt[i] = 8'($urandom);
    for (int i = 0; i < 4; i++) rv[i] = evt[i];
    @(posedge ref_clk);
    #1;
    evt = '{default: 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      m = 8'($urandom);
      i_host.write(PCR_FLG_ADDR[i], 8'h00);
      rd_chk(PCR_FLG_ADDR[i], rv[i]);
      i_host.write(PCR_FLG_ADDR[i], m);
      rd_chk(PCR_FLG_ADDR[i], rv[i] & ~m);
    end
    $display("test flags done");
    // Control registers and the inverted pair
    w = 8'($urandom);
    i_host.write(PCR_A_WD_SVC, 8'h5C);
    check("svc pulse", {7'h00, wd_pulse}, 8'h01);
    check("svc out", wd_cmd, 8'h5C);
    i_host.write(PCR_A_DEV_CTRL, w);
    i_host.write(PCR_A_DEV_CTRL_N, ~w);
    check("ctrl pulse", {7'h00, dc_pulse}, 8'h01);
    rd_chk(PCR_A_WD_SVC, 8'h5C);
    rd_chk(PCR_A_DEV_CTRL, w);
    rd_chk(PCR_A_DEV_CTRL_N, ~w);
    check("ctrl out", dc ^ dc_inv, 8'hFF);
    // Microcontroller reset clears third class only
    evt = '{default: 8'hFF};
    @(posedge ref_clk);
    #1;
    evt = '{default: 8'h00};
    i_host.write(PCR_A_CLOCK_CFG, 8'h75);
    mcu_rst_pin_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 mcu_rst_pin_n = 1'b1;
    rd_chk(PCR_A_CLOCK_CFG, 8'h00);
    rd_chk(PCR_A_WD_SVC, 8'h00);
    rd_chk(PCR_A_DEV_CTRL, w);
    rd_chk(PCR_A_OT_WARN, 8'hFF);
    // Locked entry clears second class too
    tick(locked_entry);
    for (int i = 0; i < 4; i++) rd_chk(PCR_FLG_ADDR[i], (i < 2) ? 8'hFF : 8'h00);
    rd_chk(PCR_A_DEV_CTRL, 8'h00);
    rd_chk(PCR_A_STARTUP_CFG, {su_in, su_w[3:0]});
    // Disable entry clears first class
    tick(disable_entry);
    rd_chk(PCR_A_MON_UV_FLG, 8'h00);
    rd_chk(PCR_A_STARTUP_CFG, {su_in, 4'h3});
    $display("test reset classes done");
    // Release delay for every code
    for (int c = 0; c < 8; c++)
    begin
      i_host.write(PCR_A_STARTUP_CFG, 8'(c));
      reset_hold = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check("held", {7'h00, mcu_reset_n}, 8'h00);
      reset_hold = 1'b0;
      n = 0;
      while (mcu_reset_n !== 1'b1 && n < 100)
      begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check($sformatf("release code %0d", c), 8'(n), 8'(DLY[c]));
    end
    $display("test release delay done");
    results();
  end
endmodule

// *** src/pcr_delay_timer.sv ***
`timescale 1ns/1ns
// Holds its output low while hold is high, then raises it after target cycles
module pcr_delay_timer
#(
  parameter int unsigned CW = 19
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          hold,
  input  wire logic [CW-1:0] target,
  output logic               expired
);
  logic [CW-1:0] cnt;
  wire           last = (cnt == target - 1'b1);

  // Count restarts on every hold so a short glitch gives the full delay
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt     <= '0;
      expired <= 1'b0;
    end
    else if (hold)
    begin
      cnt     <= '0;
      expired <= 1'b0;
    end
    else if (!expired)
    begin
      cnt     <= cnt + 1'b1;
      expired <= last;
    end
  end

  delay_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(expired) |-> $past(cnt) == $past(target) - 1'b1 && !$past(hold))
    else $error("release did not follow the selected delay");
endmodule

// *** src/pcr_pkg.sv ***
package pcr_pkg;

  // Timing base
  localparam int unsigned PCR_CLK_HZ     = 20_000_000;
  localparam int unsigned PCR_CYC_PER_US = PCR_CLK_HZ / 1_000_000;

  // Register port widths
  localparam int unsigned PCR_AW = 6;
  localparam int unsigned PCR_DW = 8;

  // Register addresses
  localparam logic [5:0] PCR_A_STARTUP_CFG = 6'h00;
  localparam logic [5:0] PCR_A_CLOCK_CFG   = 6'h01;
  localparam logic [5:0] PCR_A_MON_UV_FLG  = 6'h22;
  localparam logic [5:0] PCR_A_OT_FAULT    = 6'h23;
  localparam logic [5:0] PCR_A_OT_WARN     = 6'h24;
  localparam logic [5:0] PCR_A_OC_WARN     = 6'h25;
  localparam logic [5:0] PCR_A_OT_STAT     = 6'h26;
  localparam logic [5:0] PCR_A_VMON_STAT   = 6'h27;
  localparam logic [5:0] PCR_A_DEV_STATE   = 6'h28;
  localparam logic [5:0] PCR_A_PROT_STAT   = 6'h29;
  localparam logic [5:0] PCR_A_WWD_STAT    = 6'h2A;
  localparam logic [5:0] PCR_A_WD_SVC      = 6'h33;
  localparam logic [5:0] PCR_A_DEV_CTRL    = 6'h34;
  localparam logic [5:0] PCR_A_DEV_CTRL_N  = 6'h35;
  localparam logic [5:0] PCR_A_PROG_STAT   = 6'h37;
  localparam logic [5:0] PCR_A_POST_BUCK   = 6'h39;
  localparam logic [5:0] PCR_A_HW_OPTION   = 6'h3B;
  localparam logic [5:0] PCR_A_CHIP_ID     = 6'h3C;

  // Reset classes
  localparam int unsigned PCR_CLS_FIRST  = 0;
  localparam int unsigned PCR_CLS_SECOND = 1;
  localparam int unsigned PCR_CLS_THIRD  = 2;

  // Start-up configuration fields
  localparam int unsigned PCR_SU_DLY_LSB = 0;
  localparam int unsigned PCR_SU_ENA_CFG = 3;
  localparam int unsigned PCR_SU_EN_LSB  = 4;
  localparam logic [2:0]  PCR_SU_DLY_RST = 3'h3;
  localparam logic [3:0]  PCR_SU_EN_RST  = 4'hF;
  localparam logic        PCR_SU_ENA_RST = 1'b0;

  // Clock configuration fields, all reset to zero
  localparam int unsigned PCR_CK_SYNC_OUT  = 0;
  localparam int unsigned PCR_CK_SYNC_IN   = 1;
  localparam int unsigned PCR_CK_SPREAD    = 2;
  localparam int unsigned PCR_CK_SYNC_PH   = 4;
  localparam int unsigned PCR_CK_PRE_PH    = 5;
  localparam int unsigned PCR_CK_POST_PH   = 6;
  localparam logic [7:0]  PCR_CK_USED_MASK = 8'h77;

  // Clear-on-one flag registers: address and class
  localparam logic [5:0]  PCR_FLG_ADDR [4] = '{PCR_A_MON_UV_FLG, PCR_A_OT_FAULT, PCR_A_OT_WARN, PCR_A_OC_WARN};
  localparam int unsigned PCR_FLG_CLS  [4] = '{0, 0, 1, 1};

  // Hardware-updated status registers: address, reset value, class
  localparam logic [5:0]  PCR_STAT_ADDR [7] = '{PCR_A_OT_STAT, PCR_A_VMON_STAT, PCR_A_DEV_STATE, PCR_A_PROT_STAT,
                                                PCR_A_WWD_STAT, PCR_A_PROG_STAT, PCR_A_POST_BUCK};
  localparam logic [7:0]  PCR_STAT_RST  [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h02};
  localparam int unsigned PCR_STAT_CLS  [7] = '{1, 1, 1, 2, 2, 1, 1};

  // Control register reset values
  localparam logic [7:0] PCR_WD_SVC_RST  = 8'h00;
  localparam logic [7:0] PCR_DEV_CTL_RST = 8'h00;
  localparam logic [7:0] PCR_HW_OPT_RST  = 8'hD3;

  // Reset release delay per code, in microseconds and in clock cycles
  localparam int unsigned PCR_REL_DLY_US  [8] = '{200, 400, 800, 1000, 2000, 4000, 10000, 20000};
  localparam int unsigned PCR_REL_DLY_CYC [8] = '{
    200 * PCR_CYC_PER_US, 400 * PCR_CYC_PER_US, 800 * PCR_CYC_PER_US, 1000 * PCR_CYC_PER_US,
    2000 * PCR_CYC_PER_US, 4000 * PCR_CYC_PER_US, 10000 * PCR_CYC_PER_US, 20000 * PCR_CYC_PER_US};
  localparam int unsigned PCR_DLY_CW = 19;

endpackage

// *** src/pcr_regs.sv ***
`timescale 1ns/1ns
// Functional notes
// - Three reset classes clear their register groups
// - Sync-input request bit clears when done
// - Flags set by events, cleared writing one
// - Release delay code selects eight delays, default 3
// - Bit 7 shows monitor 2 start-up enable
// - Bit 6 shows monitor 1 start-up enable
// - Bit 5 shows step-up start-up enable
// - Bit 4 shows post step-down start-up enable
// - Three phase bits select 0 or 180
// - Clock bit 2 enables spread spectrum
// - Clock bit 1 requests sync input, self-clearing
// - Clock bit 0 enables sync clock output
// - Watchdog service command at 0x33, third class
// - State control 0x34, inverted copy 0x35
// - Watchdog status at 0x2A, third class
// - Programming status at 0x37, resets 0x03
// - Post step-down voltage status at 0x39
module pcr_regs
  import pcr_pkg::*;
#(
  parameter int unsigned REL_DLY_CYC [8] = PCR_REL_DLY_CYC,
  parameter logic [7:0]  HW_OPTION       = PCR_HW_OPT_RST,
  parameter logic [7:0]  CHIP_ID         = 8'h5A  // Arbitrary value
)
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        disable_entry,
  input  wire logic        locked_entry,
  input  wire logic        mcu_rst_pin_n,
  input  wire logic [7:0]  monitor_uv_evt,
  input  wire logic [7:0]  overtemp_fault_evt,
  input  wire logic [7:0]  overtemp_warn_evt,
  input  wire logic [7:0]  overcurrent_warn_evt,
  input  wire logic [7:0]  overtemp_status_in,
  input  wire logic [7:0]  vmon_status_in,
  input  wire logic [7:0]  device_state_in,
  input  wire logic [7:0]  protection_status_in,
  input  wire logic [7:0]  wwd_status_in,
  input  wire logic [7:0]  prog_support_in,
  input  wire logic [7:0]  post_buck_status_in,
  input  wire logic [3:0]  startup_enables_in,
  input  wire logic        sync_in_done,
  input  wire logic        reset_hold,
  output logic      [2:0]  reset_release_delay,
  output logic             ena_config,
  output logic      [3:0]  startup_enables,
  output logic             post_stepdown_phase,
  output logic             pre_regulator_phase,
  output logic             sync_phase,
  output logic             spread_spectrum_enable,
  output logic             sync_input_enable,
  output logic             sync_output_enable,
  output logic      [7:0]  wd_service_cmd,
  output logic             wd_service_pulse,
  output logic      [7:0]  dev_ctrl,
  output logic      [7:0]  dev_ctrl_inv,
  output logic             dev_ctrl_pulse,
  output logic             mcu_reset_n
);
  logic       rst_meta;
  logic       rst_n;
  logic       mcu_pin_level;
  logic       mcu_pin_prev;
  logic [7:0] flag_q [4];
  logic [7:0] stat_q [7];

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pcr_sync3 u_mcu_rst_sync
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (mcu_rst_pin_n),
    .level   (mcu_pin_level)
  );

  // Edge of the filtered microcontroller reset pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mcu_pin_prev <= 1'b1;
    else
      mcu_pin_prev <= mcu_pin_level;
  end

  // Each class clears its own group plus all narrower ones
  wire       mcu_rst_evt = mcu_pin_prev && !mcu_pin_level;
  wire [2:0] cls_clr;
  assign cls_clr[PCR_CLS_FIRST]  = disable_entry;
  assign cls_clr[PCR_CLS_SECOND] = cls_clr[PCR_CLS_FIRST] | locked_entry;
  assign cls_clr[PCR_CLS_THIRD]  = cls_clr[PCR_CLS_SECOND] | mcu_rst_evt;

  // Write decode; class resets load defaults through the write path so async reset stays pure
  wire wr_su   = reg_wr && (reg_addr == PCR_A_STARTUP_CFG);
  wire wr_ck   = reg_wr && (reg_addr == PCR_A_CLOCK_CFG);
  wire wr_svc  = reg_wr && (reg_addr == PCR_A_WD_SVC);
  wire wr_dc   = reg_wr && (reg_addr == PCR_A_DEV_CTRL);
  wire wr_dcn  = reg_wr && (reg_addr == PCR_A_DEV_CTRL_N);
  wire sync_input_enable_on = wr_ck && reg_wdata[PCR_CK_SYNC_IN];
  wire [7:0] su_wdata = cls_clr[PCR_CLS_FIRST] ? {PCR_SU_EN_RST, PCR_SU_ENA_RST, PCR_SU_DLY_RST} : reg_wdata;
  wire [7:0] ck_wdata = cls_clr[PCR_CLS_THIRD] ? 8'h00 : reg_wdata;

  // Start-up configuration; enable bits only track hardware
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_release_delay <= PCR_SU_DLY_RST;
      ena_config          <= PCR_SU_ENA_RST;
      startup_enables     <= PCR_SU_EN_RST;
    end
    else
    begin
      startup_enables <= cls_clr[PCR_CLS_FIRST] ? PCR_SU_EN_RST : startup_enables_in;
      if (wr_su || cls_clr[PCR_CLS_FIRST])
      begin
        reset_release_delay <= su_wdata[PCR_SU_DLY_LSB +: 3];
        ena_config          <= su_wdata[PCR_SU_ENA_CFG];
      end
    end
  end

  // Clock configuration; unused bits 7 and 3 have no storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      post_stepdown_phase    <= 1'b0;
      pre_regulator_phase    <= 1'b0;
      sync_phase             <= 1'b0;
      spread_spectrum_enable <= 1'b0;
      sync_output_enable     <= 1'b0;
      sync_input_enable      <= 1'b0;
    end
    else
    begin
      if (wr_ck || cls_clr[PCR_CLS_THIRD])
      begin
        post_stepdown_phase    <= ck_wdata[PCR_CK_POST_PH];
        pre_regulator_phase    <= ck_wdata[PCR_CK_PRE_PH];
        sync_phase             <= ck_wdata[PCR_CK_SYNC_PH];
        spread_spectrum_enable <= ck_wdata[PCR_CK_SPREAD];
        sync_output_enable     <= ck_wdata[PCR_CK_SYNC_OUT];
      end
      // A new request wins over a completion; a class reset wins over both
      if (sync_input_enable_on && !cls_clr[PCR_CLS_THIRD])
        sync_input_enable <= 1'b1;
      else if (sync_in_done || cls_clr[PCR_CLS_THIRD])
        sync_input_enable <= 1'b0;
    end
  end

  // Watchdog service command and state control pair
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_service_cmd   <= PCR_WD_SVC_RST;
      wd_service_pulse <= 1'b0;
      dev_ctrl         <= PCR_DEV_CTL_RST;
      dev_ctrl_inv     <= PCR_DEV_CTL_RST;
      dev_ctrl_pulse   <= 1'b0;
    end
    else
    begin
      wd_service_pulse <= wr_svc && !cls_clr[PCR_CLS_THIRD];
      dev_ctrl_pulse   <= wr_dcn && !cls_clr[PCR_CLS_SECOND] && (reg_wdata == ~dev_ctrl);
      if (cls_clr[PCR_CLS_THIRD])
        wd_service_cmd <= PCR_WD_SVC_RST;
      else if (wr_svc)
        wd_service_cmd <= reg_wdata;
      if (cls_clr[PCR_CLS_SECOND])
      begin
        dev_ctrl     <= PCR_DEV_CTL_RST;
        dev_ctrl_inv <= PCR_DEV_CTL_RST;
      end
      else
      begin
        if (wr_dc)
          dev_ctrl <= reg_wdata;
        if (wr_dcn)
          dev_ctrl_inv <= reg_wdata;
      end
    end
  end

  // Clear-on-one flags; an event in the clearing cycle survives
  wire [7:0] flg_evt [4];
  assign flg_evt[0] = monitor_uv_evt;
  assign flg_evt[1] = overtemp_fault_evt;
  assign flg_evt[2] = overtemp_warn_evt;
  assign flg_evt[3] = overcurrent_warn_evt;

  for (genvar i = 0; i < 4; i++)
  begin : g_flag
    wire [7:0] clr_mask = (reg_wr && (reg_addr == PCR_FLG_ADDR[i])) ? reg_wdata : 8'h00;
    wire [7:0] next_flg = cls_clr[PCR_FLG_CLS[i]] ? 8'h00 : ((flag_q[i] & ~clr_mask) | flg_evt[i]);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        flag_q[i] <= 8'h00;
      else
        flag_q[i] <= next_flg;
    end
  end

  // Status registers follow hardware; class reset reloads the default
  wire [7:0] stat_in [7];
  assign stat_in[0] = overtemp_status_in;
  assign stat_in[1] = vmon_status_in;
  assign stat_in[2] = device_state_in;
  assign stat_in[3] = protection_status_in;
  assign stat_in[4] = wwd_status_in;
  assign stat_in[5] = prog_support_in;
  assign stat_in[6] = post_buck_status_in;

  for (genvar j = 0; j < 7; j++)
  begin : g_stat
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        stat_q[j] <= PCR_STAT_RST[j];
      else if (cls_clr[PCR_STAT_CLS[j]])
        stat_q[j] <= PCR_STAT_RST[j];
      else
        stat_q[j] <= stat_in[j];
    end
  end

  // Read multiplexer; unmapped addresses return zero
  wire [7:0] rd_su = {startup_enables, ena_config, reset_release_delay};
  wire [7:0] rd_ck = {1'b0, post_stepdown_phase, pre_regulator_phase, sync_phase,
                      1'b0, spread_spectrum_enable, sync_input_enable, sync_output_enable};
  logic [7:0] rd_tab;
  always_comb
  begin
    rd_tab = 8'h00;
    for (int k = 0; k < 4; k++)
      if (reg_addr == PCR_FLG_ADDR[k])
        rd_tab = flag_q[k];
    for (int k = 0; k < 7; k++)
      if (reg_addr == PCR_STAT_ADDR[k])
        rd_tab = stat_q[k];
  end
  wire [7:0] next_rdata =
    (reg_addr == PCR_A_STARTUP_CFG) ? rd_su :
    (reg_addr == PCR_A_CLOCK_CFG)   ? rd_ck :
    (reg_addr == PCR_A_WD_SVC)      ? wd_service_cmd :
    (reg_addr == PCR_A_DEV_CTRL)    ? dev_ctrl :
    (reg_addr == PCR_A_DEV_CTRL_N)  ? dev_ctrl_inv :
    (reg_addr == PCR_A_HW_OPTION)   ? HW_OPTION :
    (reg_addr == PCR_A_CHIP_ID)     ? CHIP_ID : rd_tab;

  // Read data registered, valid one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // Reset release delay; long counts stay parameters for fast simulation
  wire [PCR_DLY_CW-1:0] dly_target = PCR_DLY_CW'(REL_DLY_CYC[reset_release_delay]);
  pcr_delay_timer #(.CW(PCR_DLY_CW)) u_rel_timer
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .hold    (reset_hold),
    .target  (dly_target),
    .expired (mcu_reset_n)
  );

  class_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cls_clr[PCR_CLS_THIRD] |=> rd_ck == 8'h00 && wd_service_cmd == 8'h00)
    else $error("third class reset left clock or service state");
  sync_input_enable_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_input_enable && sync_in_done && !sync_input_enable_on && !cls_clr[PCR_CLS_THIRD] |=> !sync_input_enable)
    else $error("sync input request not cleared on completion");
  sync_input_enable_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_input_enable_on && !cls_clr[PCR_CLS_THIRD] |=> sync_input_enable)
    else $error("sync input request not taken");
  flag_set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    monitor_uv_evt[0] && !cls_clr[PCR_CLS_FIRST] |=> flag_q[0][0])
    else $error("undervoltage event lost");
  flag_zero_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == PCR_A_OT_WARN && !reg_wdata[2] && flag_q[2][2] && !cls_clr[PCR_CLS_SECOND]
    |=> flag_q[2][2])
    else $error("writing zero changed a flag");
  startup_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == PCR_A_STARTUP_CFG |=> reg_rvalid && reg_rdata[7:4] == $past(startup_enables))
    else $error("start-up enable readback wrong");
  phase_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_ck && !cls_clr[PCR_CLS_THIRD]
    |=> {post_stepdown_phase, pre_regulator_phase, sync_phase} == $past(reg_wdata[6:4]))
    else $error("phase bits not written");
  svc_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_svc && !cls_clr[PCR_CLS_THIRD] |=> wd_service_pulse && wd_service_cmd == $past(reg_wdata))
    else $error("service command not stored");
  dev_ctrl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_dc && !cls_clr[PCR_CLS_SECOND] |=> dev_ctrl == $past(reg_wdata))
    else $error("state control not stored");
  prog_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cls_clr[PCR_CLS_SECOND] |=> stat_q[5] == 8'h03)
    else $error("programming status reset value wrong");
  unused_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == PCR_A_CLOCK_CFG |=> (reg_rdata & ~PCR_CK_USED_MASK) == 8'h00)
    else $error("unused clock bits read nonzero");
  hold_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_hold |=> !mcu_reset_n)
    else $error("reset released while held");
endmodule

// *** src/pcr_sync3.sv ***
`timescale 1ns/1ns
// Three-stage pin synchroniser; output moves only when stages two and three agree
module pcr_sync3
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second, so metastability cannot reach logic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule
